// >>> design/ced_defs.vh
`ifndef CED_DEFS_VH
`define CED_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses on the APB.
// ----------------------------------------------------------------
`define CED_A_CMD   8'h00
`define CED_A_LINK  8'h04
`define CED_A_BUF   8'h08
`define CED_A_BLK   8'h0C
`define CED_A_SCB   8'h10
`define CED_A_CTRL  8'h14
`define CED_A_STAT  8'h18
`define CED_A_RES   8'h1C
`define CED_A_NEXT  8'h20

// ----------------------------------------------------------------
// Command block layout and word fields.
// ----------------------------------------------------------------
`define CED_BO_RES   16'h0006
`define CED_ST_DONE  15
`define CED_ST_BUSY  14
`define CED_ST_OK    13
`define CED_CW_END   15
`define CED_OP_ECHO  3'h5
`define CED_OP_DUMP  3'h6
`define CED_RS_GOOD  15
`define CED_RS_XCVR  14
`define CED_RS_OPEN  13
`define CED_RS_SHORT 12
`define CED_TIME_MAX 11'h7FF

// ----------------------------------------------------------------
// Dump image byte offsets and size.
// ----------------------------------------------------------------
`define CED_D_CFG    8'h00
`define CED_D_ADDR   8'h0C
`define CED_D_PREV   8'h12
`define CED_D_TXCRC  8'h14
`define CED_D_RXCRC  8'h18
`define CED_D_RXST   8'h22
`define CED_D_HASH   8'h24
`define CED_D_ECHO   8'h2C
`define CED_D_EBC    8'h40
`define CED_D_CURFD  8'h44
`define CED_D_NXTFD  8'h46
`define CED_D_TXCNT  8'h50
`define CED_D_CMD    8'h60
`define CED_D_LINK   8'h62
`define CED_D_BLK    8'h64
`define CED_D_SCB    8'h66
`define CED_D_RXSUS  8'h7E
`define CED_D_CUST   8'h80
`define CED_IMG_BITS 1360
`define CED_LAST_WD  7'h54
`define CED_RXST_MSK 16'h2DC0
`define CED_TXCRC_HI 16
`define CED_BIT_SUSP 4
`define CED_BIT_CEND 5
`define CED_BIT_ABRT 6
`define CED_BIT_FDSUS 12
`define CED_BIT_EOF  15

`endif

// >>> design/ced_top.v
`timescale 1ns/1ps
`default_nettype none
`include "ced_defs.vh"

module ced_top (
  // System clock and reset.
  input  wire         clk,
  input  wire         rst_n,
  // APB slave.
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [7:0]   paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output reg          pready,
  output reg          pslverr,
  // Shared memory write port.
  output reg          mem_wr,
  output reg  [15:0]  mem_addr,
  output reg  [15:0]  mem_data,
  input  wire         mem_ack,
  // Serial link.
  input  wire         txc,
  input  wire         cd,
  input  wire         crs,
  output reg          tx_en,
  output reg          tx_data,
  // Device state shown by the dump.
  input  wire [87:0]  config_bytes,
  input  wire         crc16_mode,
  input  wire [47:0]  station_address,
  input  wire [31:0]  transmit_crc,
  input  wire [31:0]  receive_crc,
  input  wire [15:0]  receive_status,
  input  wire [63:0]  hash_table,
  input  wire [13:0]  current_rxbuf_empty_count,
  input  wire [15:0]  current_frame_desc_pointer,
  input  wire [15:0]  next_frame_desc_pointer,
  input  wire [13:0]  last_txbuf_byte_count,
  input  wire         last_txbuf_eof,
  input  wire         receiver_suspend_request,
  input  wire         commander_suspend_request,
  input  wire         command_abort_pending,
  input  wire         next_descriptor_suspend
);

  // ----------------------------------------------------------------
  // States.
  // ----------------------------------------------------------------
  localparam [5:0] S_IDLE = 6'b00_0001;
  localparam [5:0] S_BUSY = 6'b00_0010;
  localparam [5:0] S_ECHO = 6'b00_0100;
  localparam [5:0] S_RES  = 6'b00_1000;
  localparam [5:0] S_DUMP = 6'b01_0000;
  localparam [5:0] S_STAT = 6'b10_0000;

  reg [5:0]  state;
  reg [15:0] cmd_word;
  reg [15:0] link_offset;
  reg [15:0] buffer_offset;
  reg [15:0] executing_block_pointer;
  reg [15:0] following_block_pointer;
  reg [15:0] control_block_offset;
  reg [15:0] last_status;
  reg [13:0] prev_status;
  reg [15:0] echo_result;
  reg        result_ok;
  reg [10:0] echo_time;
  reg        crs_seen;
  reg [6:0]  dump_idx;
  reg [2:0]  txc_q;
  reg [2:0]  cd_q;
  reg [2:0]  crs_q;
  reg [1359:0] img;

  // Register decode; 4'hF marks an unmapped address.
  function [3:0] reg_index;
    input [7:0] a;
    begin
      if (a == `CED_A_CMD) begin
        reg_index = 4'h0;
      end else if (a == `CED_A_LINK) begin
        reg_index = 4'h1;
      end else if (a == `CED_A_BUF) begin
        reg_index = 4'h2;
      end else if (a == `CED_A_BLK) begin
        reg_index = 4'h3;
      end else if (a == `CED_A_SCB) begin
        reg_index = 4'h4;
      end else if (a == `CED_A_CTRL) begin
        reg_index = 4'h5;
      end else if (a == `CED_A_STAT) begin
        reg_index = 4'h6;
      end else if (a == `CED_A_RES) begin
        reg_index = 4'h7;
      end else if (a == `CED_A_NEXT) begin
        reg_index = 4'h8;
      end else begin
        reg_index = 4'hF;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Link input synchronisers.
  // ----------------------------------------------------------------

  // Two flops per pin, plus a third stage kept only for edge finding.
  always @(posedge clk) begin
    if (!rst_n) begin
      txc_q <= 3'h0;
      cd_q  <= 3'h0;
      crs_q <= 3'h0;
    end else begin
      txc_q <= {txc_q[1:0], txc};
      cd_q  <= {cd_q[1:0], cd};
      crs_q <= {crs_q[1:0], crs};
    end
  end

  wire txc_rise = txc_q[1] & ~txc_q[2];
  wire cd_rise  = cd_q[1] & ~cd_q[2];
  wire crs_fall = ~crs_q[1] & crs_q[2];
  wire crs_now  = crs_q[1];

  // ----------------------------------------------------------------
  // Dump image.
  // ----------------------------------------------------------------

  // Bytes sit low byte first; unlisted bytes write as zero.
  always @* begin
    img = {`CED_IMG_BITS{1'b0}};
    img[8*`CED_D_CFG +: 88] = config_bytes;
    img[8*`CED_D_ADDR +: 48] = station_address;
    img[8*`CED_D_PREV +: 14] = prev_status;
    img[8*`CED_D_TXCRC +: 32] = transmit_crc;
    if (crc16_mode) begin
      img[8*`CED_D_TXCRC + `CED_TXCRC_HI +: 16] = 16'h0000;
    end
    img[8*`CED_D_RXCRC +: 32] = receive_crc;
    img[8*`CED_D_RXST +: 16] =
      receive_status & `CED_RXST_MSK;
    img[8*`CED_D_HASH +: 64] = hash_table;
    img[8*`CED_D_ECHO +: 16] = echo_result;
    img[8*`CED_D_EBC +: 14] = current_rxbuf_empty_count;
    img[8*`CED_D_CURFD +: 16] = current_frame_desc_pointer;
    img[8*`CED_D_NXTFD +: 16] = next_frame_desc_pointer;
    img[8*`CED_D_TXCNT +: 14] = last_txbuf_byte_count;
    img[8*`CED_D_TXCNT + `CED_BIT_EOF] = last_txbuf_eof;
    img[8*`CED_D_CMD +: 16] = cmd_word;
    img[8*`CED_D_LINK +: 16] = link_offset;
    img[8*`CED_D_BLK +: 16] = executing_block_pointer;
    img[8*`CED_D_SCB +: 16] = control_block_offset;
    img[8*`CED_D_RXSUS + `CED_BIT_SUSP] = receiver_suspend_request;
    img[8*`CED_D_CUST + `CED_BIT_SUSP] = commander_suspend_request;
    img[8*`CED_D_CUST + `CED_BIT_CEND] = cmd_word[`CED_CW_END];
    img[8*`CED_D_CUST + `CED_BIT_ABRT] = command_abort_pending;
    img[8*`CED_D_CUST + `CED_BIT_FDSUS] = next_descriptor_suspend;
  end

  // ----------------------------------------------------------------
  // Bus slave and command sequencer.
  // ----------------------------------------------------------------

  wire       acc    = psel & penable;
  wire       wr_hit = acc & pready & pwrite;
  wire [3:0] wsel   = reg_index(paddr);
  wire       start  = wr_hit & (wsel == 4'h5) & pwdata[0];
  wire [2:0] opcode = cmd_word[2:0];

  // One wait state per access; writes land on the completing edge.
  always @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      state   <= S_IDLE;
      cmd_word <= 16'h0000;
      link_offset <= 16'h0000;
      buffer_offset <= 16'h0000;
      executing_block_pointer <= 16'h0000;
      following_block_pointer <= 16'h0000;
      control_block_offset <= 16'h0000;
      last_status <= 16'h0000;
      prev_status <= 14'h0000;
      echo_result <= 16'h0000;
      result_ok <= 1'b0;
      echo_time <= 11'h000;
      crs_seen <= 1'b0;
      dump_idx <= 7'h00;
      mem_wr   <= 1'b0;
      mem_addr <= 16'h0000;
      mem_data <= 16'h0000;
      tx_en    <= 1'b0;
      tx_data  <= 1'b0;
    end else begin
      // Bus answer.
      if (acc & ~pready) begin
        pready  <= 1'b1;
        pslverr <= (wsel == 4'hF);
        prdata  <= 32'h0000_0000;
        if (wsel == 4'h0) begin
          prdata[15:0] <= cmd_word;
        end else if (wsel == 4'h1) begin
          prdata[15:0] <= link_offset;
        end else if (wsel == 4'h2) begin
          prdata[15:0] <= buffer_offset;
        end else if (wsel == 4'h3) begin
          prdata[15:0] <= executing_block_pointer;
        end else if (wsel == 4'h4) begin
          prdata[15:0] <= control_block_offset;
        end else if (wsel == 4'h5) begin
          prdata[0] <= ~state[0];
        end else if (wsel == 4'h6) begin
          prdata[15:0] <= last_status;
        end else if (wsel == 4'h7) begin
          prdata[15:0] <= echo_result;
        end else if (wsel == 4'h8) begin
          prdata[15:0] <= following_block_pointer;
        end
      end else begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
      end
      // Block fields are frozen while a command runs.
      if (wr_hit & state[0]) begin
        if (wsel == 4'h0) begin
          cmd_word <= pwdata[15:0];
        end else if (wsel == 4'h1) begin
          link_offset <= pwdata[15:0];
        end else if (wsel == 4'h2) begin
          buffer_offset <= pwdata[15:0];
        end else if (wsel == 4'h3) begin
          executing_block_pointer <= pwdata[15:0];
        end else if (wsel == 4'h4) begin
          control_block_offset <= pwdata[15:0];
        end
      end
      // Sequencer.
      case (state)
        S_IDLE: begin
          if (start) begin
            state <= S_BUSY;
          end
        end
        S_BUSY: begin
          if (!mem_wr) begin
            mem_wr   <= 1'b1;
            mem_addr <= executing_block_pointer;
            mem_data <= 16'h0001 << `CED_ST_BUSY;
          end else if (mem_ack) begin
            mem_wr    <= 1'b0;
            result_ok <= 1'b0;
            echo_time <= 11'h000;
            crs_seen  <= 1'b0;
            dump_idx  <= 7'h00;
            if (opcode == `CED_OP_ECHO) begin
              state <= S_ECHO;
            end else if (opcode == `CED_OP_DUMP) begin
              state <= S_DUMP;
            end else begin
              state <= S_STAT;
            end
          end
        end
        S_ECHO: begin
          tx_en   <= 1'b1;
          tx_data <= 1'b1;
          if (crs_now) begin
            crs_seen <= 1'b1;
          end
          if (cd_rise) begin
            tx_en       <= 1'b0;
            tx_data     <= 1'b0;
            echo_result <= (16'h0001 << `CED_RS_OPEN) |
                           {5'h00, echo_time};
            state       <= S_RES;
          end else if (crs_fall & crs_seen) begin
            tx_en       <= 1'b0;
            tx_data     <= 1'b0;
            echo_result <= (16'h0001 << `CED_RS_SHORT) |
                           {5'h00, echo_time};
            state       <= S_RES;
          end else if (txc_rise) begin
            if (echo_time == `CED_TIME_MAX) begin
              tx_en   <= 1'b0;
              tx_data <= 1'b0;
              state   <= S_RES;
              if (crs_seen | crs_now) begin
                echo_result <= 16'h0001 << `CED_RS_GOOD;
              end else begin
                echo_result <= (16'h0001 << `CED_RS_XCVR) |
                               {5'h00, echo_time};
              end
            end else begin
              echo_time <= echo_time + 11'h001;
            end
          end
        end
        S_RES: begin
          if (!mem_wr) begin
            mem_wr   <= 1'b1;
            mem_addr <= executing_block_pointer + `CED_BO_RES;
            mem_data <= echo_result;
          end else if (mem_ack) begin
            mem_wr    <= 1'b0;
            result_ok <= 1'b1;
            state     <= S_STAT;
          end
        end
        S_DUMP: begin
          if (!mem_wr) begin
            mem_wr   <= 1'b1;
            mem_addr <= buffer_offset + {8'h00, dump_idx, 1'b0};
            mem_data <= img[{dump_idx, 4'h0} +: 16];
          end else if (mem_ack) begin
            mem_wr   <= 1'b0;
            dump_idx <= dump_idx + 7'h01;
            if (dump_idx == `CED_LAST_WD) begin
              result_ok <= 1'b1;
              state     <= S_STAT;
            end
          end
        end
        S_STAT: begin
          if (!mem_wr) begin
            mem_wr   <= 1'b1;
            mem_addr <= executing_block_pointer;
            mem_data <= (16'h0001 << `CED_ST_DONE) |
                        ({15'h0000, result_ok} << `CED_ST_OK);
          end else if (mem_ack) begin
            mem_wr      <= 1'b0;
            last_status <= mem_data;
            prev_status <= mem_data[13:0];
            following_block_pointer <= link_offset;
            if (!cmd_word[`CED_CW_END]) begin
              executing_block_pointer <= link_offset;
            end
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule // ced_top

`default_nettype wire

// >>> testbench/ced_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------
module ced_chk (
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_n,
  // Watched ports.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        mem_wr,
  input wire logic        mem_ack,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_data,
  input wire logic        cd,
  input wire logic        crs,
  input wire logic        tx_en,
  input wire logic        tx_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Steps of one memory word transfer.
  sequence wr_wait; mem_wr && !mem_ack; endsequence
  sequence wr_done; mem_wr && mem_ack; endsequence
  reset_idle_a: assert property (disable iff (1'b0)
    !rst_n |=> !mem_wr && !tx_en && !pready) else $error("busy in reset");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  mem_hold_a: assert property (wr_wait |=> mem_wr && $stable(mem_addr)
    && $stable(mem_data)) else $error("memory request changed");
  mem_gap_a: assert property (wr_done |=> !mem_wr)
    else $error("no gap after memory word");
  ones_sent_a: assert property (tx_en |-> tx_data)
    else $error("pattern not all ones");
  collision_echo_a: assert property ($rose(cd) && tx_en |-> ##[1:12] !tx_en)
    else $error("collision echo ignored");
  carrier_echo_a: assert property (tx_en && $fell(crs) |-> ##[1:12] !tx_en)
    else $error("carrier drop ignored");
  result_write_a: assert property ($past(tx_en) && !tx_en
    |-> ##[0:12] mem_wr) else $error("no result after test");
  busy_mark_a: assert property ($rose(tx_en) |-> mem_data == 16'h4000)
    else $error("busy word not written first");
endmodule // ced_chk
bind ced_top ced_chk u_chk (.clk, .rst_n, .psel, .penable, .pready,
  .pslverr, .mem_wr, .mem_ack, .mem_addr, .mem_data, .cd, .crs, .tx_en,
  .tx_data);
`default_nettype wire

// >>> testbench/ced_host_mem.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host shared memory
// ----------------------------------------------------------------
module ced_host_mem (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Memory write port.
  input  wire logic        mem_wr,
  input  wire logic [15:0] mem_addr,
  input  wire logic [15:0] mem_data,
  output var  logic        mem_ack,
  // Stall select.
  input  wire logic        slow
);
  logic [15:0] m [0:1023];
  logic [1:0]  wait_cnt;
  // Accept each word after an optional stall and store it one edge later, while ack is high.
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    if (!rst_n) begin
      wait_cnt <= 2'd0;
    end else if (mem_wr && !mem_ack) begin
      if (wait_cnt == 2'd0) begin
        mem_ack  <= 1'b1;
        wait_cnt <= slow ? 2'd3 : 2'd0;
      end else begin
        wait_cnt <= wait_cnt - 2'd1;
      end
    end
    if (mem_wr && mem_ack) begin
      m[mem_addr[10:1]] <= mem_data;
    end
  end
endmodule // ced_host_mem
`default_nettype wire

// >>> testbench/tb_cable_echo_and_state_dump.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cable_echo_and_state_dump;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic          clk, rst_n, psel, penable, pwrite, slow, se;
  logic          mem_wr, mem_ack, txc, cd, crs, tx_en, tx_data;
  logic          pready, pslverr, crc16_mode, eof, rsr, csr, abrt, nds;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, tx_crc, rx_crc, rd;
  logic [15:0]   mem_addr, mem_data, rx_st, cur_fd, nxt_fd, echo_res;
  logic [87:0]   cfg;
  logic [47:0]   sta;
  logic [63:0]   hash;
  logic [13:0]   ebc, txcnt;
  logic [1359:0] img;
  int            err_total, comparisons, cycles;
  ced_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack),
    .txc(txc), .cd(cd), .crs(crs), .tx_en(tx_en), .tx_data(tx_data),
    .config_bytes(cfg), .crc16_mode(crc16_mode), .station_address(sta),
    .transmit_crc(tx_crc), .receive_crc(rx_crc), .receive_status(rx_st),
    .hash_table(hash), .current_rxbuf_empty_count(ebc),
    .current_frame_desc_pointer(cur_fd), .next_frame_desc_pointer(nxt_fd),
    .last_txbuf_byte_count(txcnt), .last_txbuf_eof(eof),
    .receiver_suspend_request(rsr), .commander_suspend_request(csr),
    .command_abort_pending(abrt), .next_descriptor_suspend(nds));
  ced_host_mem u_mem (.clk(clk), .rst_n(rst_n), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_data(mem_data), .mem_ack(mem_ack),
    .slow(slow));
  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cut a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      err_total = err_total + 1;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic launch(input logic [15:0] cmd, input logic [15:0] blk);
    slow <= 1'($urandom_range(0, 1));
    apb(1'b1, 8'h00, {16'h0000, cmd});
    apb(1'b1, 8'h04, 32'h0000_0180);
    apb(1'b1, 8'h08, 32'h0000_0100);
    apb(1'b1, 8'h0C, {16'h0000, blk});
    apb(1'b1, 8'h10, 32'h0000_0040);
    apb(1'b1, 8'h14, 32'h0000_0001);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0 && n < 30000) begin
      apb(1'b0, 8'h14, 32'h0000_0000);
      n = n + 1;
    end
  endtask
  // Echo after k clock rises: 0 open, 1 short, 2 none, 3 no carrier.
  task automatic echo_test(input int k, input int mode);
    int n;
    crs <= (mode == 1 || mode == 2);
    launch(16'h8005, 16'h0020);
    n = 0;
    while (tx_en !== 1'b1 && n < 100) begin
      @(posedge clk);
      n = n + 1;
    end
    n = 0;
    while (n < k && tx_en === 1'b1) begin
      txc <= 1'b1;
      repeat (8) @(posedge clk);
      txc <= 1'b0;
      repeat (8) @(posedge clk);
      n = n + 1;
    end
    if (mode == 0) cd <= 1'b1;
    else crs <= 1'b0;
    wait_done();
    cd <= 1'b0;
    echo_res = mode == 0 ? 16'h2000 | 16'(k) :
               mode == 1 ? 16'h1000 | 16'(k) :
               mode == 2 ? 16'h8000 : 16'h4000 | 16'h07FF;
    chk(u_mem.m[19], echo_res);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk(rd, {16'h0000, echo_res});
    chk(u_mem.m[16], 16'hA000);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0020);
    $display("reflectometry test done");
  endtask
  task automatic dump(input int r);
    logic [127:0] p;
    p = {$urandom, $urandom, $urandom, $urandom};
    cfg <= p[87:0];
    sta <= p[127:80];
    {tx_crc, rx_crc, hash} <= {$urandom, $urandom, $urandom, $urandom};
    p = {$urandom, $urandom, $urandom, $urandom};
    {rx_st, cur_fd, nxt_fd, ebc, txcnt} <= p[75:0];
    {eof, rsr, csr, abrt, nds} <= p[80:76];
    crc16_mode <= r[0];
    launch(16'h0006, 16'h0200);
    wait_done();
    img = '0;
    img[87:0] = cfg;
    img[96 +: 48] = sta;
    img[144 +: 16] = 16'h2000;
    img[160 +: 32] = crc16_mode ? {16'h0000, tx_crc[15:0]} : tx_crc;
    img[192 +: 32] = rx_crc;
    img[272 +: 16] = rx_st & 16'h2DC0;
    img[288 +: 64] = hash;
    img[352 +: 16] = echo_res;
    img[512 +: 16] = {2'b00, ebc};
    img[544 +: 32] = {nxt_fd, cur_fd};
    img[640 +: 16] = {eof, 1'b0, txcnt};
    img[768 +: 64] = 64'h0040_0200_0180_0006;
    img[1008 +: 16] = {11'h000, rsr, 4'h0};
    img[1024 +: 16] = {3'h0, nds, 5'h00, abrt, 1'b0, csr, 4'h0};
    for (int i = 0; i < 85; i++)
      chk(u_mem.m[128 + i], img[16 * i +: 16]);
    chk(u_mem.m[256], 16'hA000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0180);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0180);
    $display("dump test done");
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, slow, txc, cd, crs} = '0;
    {crc16_mode, eof, rsr, csr, abrt, nds, paddr, pwdata} = '0;
    {cfg, sta, tx_crc, rx_crc, rx_st, hash, ebc, cur_fd} = '0;
    {nxt_fd, txcnt, echo_res} = '0;
    {err_total, comparisons, cycles} = '0;
    rd = $urandom(32'h00782d78);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk(32'(se), 32'h0000_0001);
    $display("register test done");
    echo_test($urandom_range(3, 40), 0);
    echo_test($urandom_range(3, 40), 1);
    for (int r = 0; r < 2; r++) dump(r);
    launch(16'h8003, 16'h0020);
    wait_done();
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk(rd, 32'h0000_8000);
    $display("unknown command test done");
    echo_test(2100, 2);
    echo_test(2100, 3);
    close_out();
  end
endmodule // tb_cable_echo_and_state_dump
`default_nettype wire
